/* File: sclh_pkg.sv */
// package for the serial control lead handler: modes, lead settings, timing
// assumes a 20 MHz ref_clk; all other files import it whole
package sclh_pkg;

  typedef enum logic [1:0] {
    SCLH_LINE_EIA530,
    SCLH_LINE_V35,
    SCLH_LINE_X21
  } sclh_line_e;

  typedef enum logic [1:0] {
    SCLH_OUT_NORMAL,
    SCLH_OUT_ASSERT,
    SCLH_OUT_DEASSERT
  } sclh_out_e;

  typedef enum logic [1:0] {
    SCLH_IN_NORMAL,
    SCLH_IN_IGNORE,
    SCLH_IN_REQUIRE
  } sclh_in_e;

  typedef enum logic [2:0] {
    SCLH_LB_NONE,
    SCLH_LB_LOCAL,
    SCLH_LB_REMOTE,
    SCLH_LB_PARTNER_LOCAL,
    SCLH_LB_PARTNER_REMOTE
  } sclh_lb_e;

  // to-partner lead settings
  typedef struct packed {
    sclh_out_e dtr;
    sclh_out_e rts;
    sclh_out_e ctl;
  } sclh_out_cfg_s;

  // from-partner lead settings
  typedef struct packed {
    sclh_in_e cts;
    sclh_in_e dcd;
    sclh_in_e dsr;
    sclh_in_e ind;
    sclh_in_e tm;
  } sclh_in_cfg_s;

  // per-lead polarity inversion, 1 = negative
  typedef struct packed {
    logic cts;
    logic dcd;
    logic dsr;
    logic dtr;
    logic rts;
    logic tm;
    logic ctl;
    logic ind;
  } sclh_pol_s;

  // raw from-partner leads
  typedef struct packed {
    logic cts;
    logic dcd;
    logic dsr;
    logic tm;
    logic ind;
  } sclh_leads_s;

  // serial data and clock pair
  typedef struct packed {
    logic data;
    logic clk;
  } sclh_ser_s;

  localparam int unsigned SCLH_CLK_HZ      = 20_000_000;
  localparam int unsigned SCLH_MS_PER_S    = 1000;
  localparam int unsigned SCLH_CYC_PER_MS  = SCLH_CLK_HZ / SCLH_MS_PER_S;
  localparam int unsigned SCLH_DUR_MS_MIN  = 1;
  localparam int unsigned SCLH_DUR_MS_MAX  = 1000;
  localparam int unsigned SCLH_INT_S_MIN   = 1;
  localparam int unsigned SCLH_INT_S_MAX   = 31;
  localparam int unsigned SCLH_SYNC_STAGES = 2;
  localparam logic [9:0]  SCLH_DUR_RST     = 10'h001;
  localparam logic [4:0]  SCLH_INT_RST     = 5'h01;

endpackage : sclh_pkg

/* File: sclh_sync.sv */
// two flip-flop synchroniser for a bus of lead inputs
// assumes inputs come from pins outside the ref_clk domain
`timescale 1ns/100ps
module sclh_sync
  import sclh_pkg::*;
#(
  parameter int unsigned W = 1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // first stage read only by the second
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule : sclh_sync

/* File: sclh_tick.sv */
// divider giving one-cycle ticks every DIV enabled cycles
// assumes the same ref_clk and enable as the main block
`timescale 1ns/100ps
module sclh_tick
  import sclh_pkg::*;
#(
  parameter int unsigned DIV = SCLH_CYC_PER_MS
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic clk_en,
  input  wire logic clear,
  output logic      tick
);

  localparam int unsigned CW = $clog2(DIV + 1);
  localparam logic [CW-1:0] LAST = CW'(DIV - 1);

  logic [CW-1:0] cnt_q;

  // free count, restarted by clear
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (clk_en) begin
      if (clear || cnt_q == LAST) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign tick = clk_en && !clear && (cnt_q == LAST);

endmodule : sclh_tick

/* File: sclh_top.sv */
// What this block does
// - eia-530/v.35: dtr and rts each forced on, forced off or normal.
// - x.21: control output forced on, forced off or normal.
// - eia-530/v.35: cts, dcd, dsr each ignore, normal or require.
// - x.21: indication input ignore, normal or require.
// - test-mode setting only in eia-530; rejected in v.35 and x.21.
// - require gates link on the lead; ignore disregards the lead.
// - dtr resync pulse, 1..1000 ms long, repeating every 1..31 s.
// - ignore-all disregards all leads, accepted only with no lead options set.
// - after reset or cleared setting, every lead is normal.
// - x.21 rejects eia leads; eia-530/v.35 reject control and indication.
// - dtr circuit balanced or unbalanced, balanced after reset.
// - lead high when plus wire is above minus wire.
// - polarities positive by default; eia leads invertible independently.
// - x.21 control and indication polarity invertible independently.
// - remote loopback returns tx data and clock to own receiver.
// - remote loopback sends line rx data and clock back out as tx.
// - partner loopbacks drive the eia-530 loopback-request leads.
// - loopbacks: eia-530 all four, v.35 local/remote, x.21 none.
// - local loopback turns tx to rx just before the transceiver.
//
// control lead handler for a synchronous serial port
// assumes settings are quasi-static ports; lead pins and line clock are async
`timescale 1ns/100ps
module sclh_top
  import sclh_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire logic          clk_en,
  input  wire sclh_line_e    line_mode,
  input  wire sclh_out_cfg_s out_cfg,
  input  wire sclh_in_cfg_s  in_cfg,
  input  wire sclh_pol_s     pol_cfg,
  input  wire logic          ignore_all,
  input  wire logic          dtr_unbal,
  input  wire logic          resync_en,
  input  wire logic [9:0]    resync_ms,
  input  wire logic [4:0]    resync_s,
  input  wire sclh_lb_e      lb_mode,
  input  wire logic          host_dtr,
  input  wire logic          host_rts,
  input  wire logic          host_ctl,
  input  wire sclh_ser_s     host_tx,
  output sclh_ser_s          host_rx,
  input  wire sclh_ser_s     line_rx,
  output sclh_ser_s          line_tx,
  input  wire sclh_leads_s   lead_pins,
  output logic               dtr_pin,
  output logic               dtr_unbal_sel,
  output logic               rts_pin,
  output logic               ctl_pin,
  output logic               lb_req_local,
  output logic               lb_req_remote,
  output sclh_leads_s        lead_status,
  output logic               link_ok,
  output logic               cfg_err,
  output logic               resync_active
);

  sclh_leads_s lead_s;
  sclh_ser_s   rx_s;
  logic        is_x21;
  logic        is_eia;
  logic        opt_set;
  logic        cfg_bad_d;
  logic        ign_all_ok;
  logic        ms_tick;
  logic        dtr_lvl_d;
  logic        rts_lvl_d;
  logic        ctl_lvl_d;
  logic        ok_d;
  sclh_lb_e    lb_eff;

  // pins enter the ref_clk domain through two flops
  sclh_sync #(.W ($bits(sclh_leads_s))) u_lead_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (lead_pins),
    .sync_out (lead_s)
  );

  // line data and its clock are sampled as ordinary async inputs
  sclh_sync #(.W ($bits(sclh_ser_s))) u_line_sync (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .clk_en   (clk_en),
    .async_in (line_rx),
    .sync_out (rx_s)
  );

  // millisecond time base for resync
  sclh_tick #(.DIV (SCLH_CYC_PER_MS)) u_ms_tick (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .clk_en  (clk_en),
    .clear   (!resync_en),
    .tick    (ms_tick)
  );

  assign is_x21 = (line_mode == SCLH_LINE_X21);
  assign is_eia = (line_mode == SCLH_LINE_EIA530);

  // settings check: rejected options raise cfg_err and fall back to normal
  always_comb begin
    opt_set = (out_cfg.dtr != SCLH_OUT_NORMAL) || (out_cfg.rts != SCLH_OUT_NORMAL)
           || (out_cfg.ctl != SCLH_OUT_NORMAL) || (in_cfg.cts != SCLH_IN_NORMAL)
           || (in_cfg.dcd != SCLH_IN_NORMAL) || (in_cfg.dsr != SCLH_IN_NORMAL)
           || (in_cfg.ind != SCLH_IN_NORMAL) || (in_cfg.tm != SCLH_IN_NORMAL)
           || resync_en;
    cfg_bad_d = 1'b0;
    if (is_x21) begin
      cfg_bad_d = (out_cfg.dtr != SCLH_OUT_NORMAL) || (out_cfg.rts != SCLH_OUT_NORMAL)
               || (in_cfg.cts != SCLH_IN_NORMAL) || (in_cfg.dcd != SCLH_IN_NORMAL)
               || (in_cfg.dsr != SCLH_IN_NORMAL) || resync_en || dtr_unbal
               || pol_cfg.cts || pol_cfg.dcd || pol_cfg.dsr || pol_cfg.dtr
               || pol_cfg.rts;
    end else begin
      cfg_bad_d = (out_cfg.ctl != SCLH_OUT_NORMAL) || (in_cfg.ind != SCLH_IN_NORMAL)
               || pol_cfg.ctl || pol_cfg.ind;
    end
    if (!is_eia && ((in_cfg.tm != SCLH_IN_NORMAL) || pol_cfg.tm)) begin
      cfg_bad_d = 1'b1;
    end
    if (is_x21 && lb_mode != SCLH_LB_NONE) begin
      cfg_bad_d = 1'b1;
    end
    if (!is_eia && (lb_mode == SCLH_LB_PARTNER_LOCAL || lb_mode == SCLH_LB_PARTNER_REMOTE)) begin
      cfg_bad_d = 1'b1;
    end
    if (ignore_all && opt_set) begin
      cfg_bad_d = 1'b1;
    end
  end

  assign ign_all_ok = ignore_all && !opt_set;
  assign lb_eff = cfg_bad_d ? SCLH_LB_NONE : lb_mode;

  // resync pulse timer in ms and seconds
  logic [9:0] ms_cnt_q;
  logic [4:0] s_cnt_q;
  logic       pulse_q;
  logic [9:0] dur_ms;
  logic [4:0] int_s;

  assign dur_ms = (resync_ms < 10'(SCLH_DUR_MS_MIN)) ? SCLH_DUR_RST
                : (resync_ms > 10'(SCLH_DUR_MS_MAX)) ? 10'(SCLH_DUR_MS_MAX) : resync_ms;
  assign int_s  = (resync_s < 5'(SCLH_INT_S_MIN)) ? SCLH_INT_RST : resync_s;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ms_cnt_q <= '0;
      s_cnt_q  <= '0;
      pulse_q  <= 1'b0;
    end else if (clk_en) begin
      if (!resync_en || is_x21) begin
        ms_cnt_q <= '0;
        s_cnt_q  <= '0;
        pulse_q  <= 1'b0;
      end else if (ms_tick) begin
        if (pulse_q) begin
          if (ms_cnt_q + 10'h001 >= dur_ms) begin
            pulse_q  <= 1'b0;
            ms_cnt_q <= '0;
          end else begin
            ms_cnt_q <= ms_cnt_q + 10'h001;
          end
        end else if (ms_cnt_q + 10'h001 >= 10'(SCLH_MS_PER_S)) begin
          ms_cnt_q <= '0;
          if (s_cnt_q + 5'h01 >= int_s) begin
            s_cnt_q <= '0;
            pulse_q <= 1'b1;
          end else begin
            s_cnt_q <= s_cnt_q + 5'h01;
          end
        end else begin
          ms_cnt_q <= ms_cnt_q + 10'h001;
        end
      end
    end
  end

  // output lead levels before polarity
  always_comb begin
    dtr_lvl_d = host_dtr;
    rts_lvl_d = host_rts;
    ctl_lvl_d = host_ctl;
    if (!cfg_bad_d && !is_x21) begin
      case (out_cfg.dtr)
        SCLH_OUT_ASSERT:   dtr_lvl_d = 1'b1;
        SCLH_OUT_DEASSERT: dtr_lvl_d = 1'b0;
        default:           dtr_lvl_d = host_dtr;
      endcase
      case (out_cfg.rts)
        SCLH_OUT_ASSERT:   rts_lvl_d = 1'b1;
        SCLH_OUT_DEASSERT: rts_lvl_d = 1'b0;
        default:           rts_lvl_d = host_rts;
      endcase
      if (pulse_q) begin
        dtr_lvl_d = 1'b0;
      end
    end else if (!cfg_bad_d) begin
      case (out_cfg.ctl)
        SCLH_OUT_ASSERT:   ctl_lvl_d = 1'b1;
        SCLH_OUT_DEASSERT: ctl_lvl_d = 1'b0;
        default:           ctl_lvl_d = host_ctl;
      endcase
    end
  end

  // link usable check on synchronised leads
  function automatic logic sclh_gate(input sclh_in_e s, input logic lvl);
    sclh_gate = (s == SCLH_IN_REQUIRE) ? lvl : 1'b1;
  endfunction : sclh_gate

  sclh_leads_s lead_p;
  assign lead_p = lead_s ^ {pol_cfg.cts, pol_cfg.dcd, pol_cfg.dsr, pol_cfg.tm, pol_cfg.ind};

  always_comb begin
    ok_d = 1'b1;
    if (!ign_all_ok && !cfg_bad_d && is_x21) begin
      ok_d = sclh_gate(in_cfg.ind, lead_p.ind);
    end else if (!ign_all_ok && !cfg_bad_d) begin
      ok_d = sclh_gate(in_cfg.cts, lead_p.cts) && sclh_gate(in_cfg.dcd, lead_p.dcd)
          && sclh_gate(in_cfg.dsr, lead_p.dsr);
      if (is_eia) begin
        ok_d = ok_d && sclh_gate(in_cfg.tm, lead_p.tm);
      end
    end
  end

  // registered lead outputs and status
  // reset drives all lead pins, lead status and link_ok low
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dtr_pin       <= 1'b0;
      rts_pin       <= 1'b0;
      ctl_pin       <= 1'b0;
      dtr_unbal_sel <= 1'b0;
      lead_status   <= '0;
      link_ok       <= 1'b0;
      cfg_err       <= 1'b0;
      resync_active <= 1'b0;
    end else if (clk_en) begin
      dtr_pin       <= dtr_lvl_d ^ (pol_cfg.dtr && !is_x21);
      rts_pin       <= rts_lvl_d ^ (pol_cfg.rts && !is_x21);
      ctl_pin       <= ctl_lvl_d ^ (pol_cfg.ctl && is_x21);
      dtr_unbal_sel <= dtr_unbal && !is_x21;
      lead_status   <= lead_p;
      link_ok       <= ok_d;
      cfg_err       <= cfg_bad_d;
      resync_active <= pulse_q;
    end
  end

  // loopback data paths
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rx       <= '0;
      line_tx       <= '0;
      lb_req_local  <= 1'b0;
      lb_req_remote <= 1'b0;
    end else if (clk_en) begin
      lb_req_local  <= (lb_eff == SCLH_LB_PARTNER_LOCAL);
      lb_req_remote <= (lb_eff == SCLH_LB_PARTNER_REMOTE);
      case (lb_eff)
        SCLH_LB_LOCAL: begin
          host_rx <= host_tx;
          line_tx <= host_tx;
        end
        SCLH_LB_REMOTE: begin
          host_rx <= host_tx;
          line_tx <= rx_s;
        end
        default: begin
          host_rx <= rx_s;
          line_tx <= host_tx;
        end
      endcase
    end
  end

  // checks
  property p_req_gate;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !cfg_bad_d && !ign_all_ok && !is_x21 && in_cfg.cts == SCLH_IN_REQUIRE
       && !lead_p.cts) |=> !link_ok;
  endproperty
  a_req_gate: assert property (p_req_gate) else $error("require not gating link");
  property p_dtr_force;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !cfg_bad_d && !is_x21 && out_cfg.dtr == SCLH_OUT_ASSERT && !pulse_q)
      |=> dtr_pin == !$past(pol_cfg.dtr);
  endproperty
  a_dtr_force: assert property (p_dtr_force) else $error("dtr not forced");
  property p_ctl_force;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && !cfg_bad_d && is_x21 && out_cfg.ctl == SCLH_OUT_DEASSERT)
      |=> ctl_pin == $past(pol_cfg.ctl);
  endproperty
  a_ctl_force: assert property (p_ctl_force) else $error("control not forced");
  property p_x21_reject;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && is_x21 && in_cfg.cts != SCLH_IN_NORMAL) |=> cfg_err;
  endproperty
  a_x21_reject: assert property (p_x21_reject) else $error("x.21 cts not rejected");
  property p_tm_reject;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && line_mode == SCLH_LINE_V35 && in_cfg.tm != SCLH_IN_NORMAL) |=> cfg_err;
  endproperty
  a_tm_reject: assert property (p_tm_reject) else $error("v.35 tm not rejected");
  property p_ign_all;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && ignore_all && opt_set) |=> cfg_err;
  endproperty
  a_ign_all: assert property (p_ign_all) else $error("ignore-all with options accepted");
  property p_x21_no_lb;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && is_x21) |=> !lb_req_local && !lb_req_remote;
  endproperty
  a_x21_no_lb: assert property (p_x21_no_lb) else $error("x.21 loopback request");
  property p_remote_lb;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && lb_eff == SCLH_LB_REMOTE) |=> line_tx == $past(rx_s);
  endproperty
  a_remote_lb: assert property (p_remote_lb) else $error("remote loop not returned");
  property p_local_lb;
    @(posedge ref_clk) disable iff (!rst_n)
      (clk_en && lb_eff == SCLH_LB_LOCAL) |=> host_rx == $past(host_tx);
  endproperty
  a_local_lb: assert property (p_local_lb) else $error("local loop not turned");

  c_pulse: cover property (@(posedge ref_clk) $rose(resync_active));
  c_link_drop: cover property (@(posedge ref_clk) $fell(link_ok));
  c_partner_lb: cover property (@(posedge ref_clk) lb_req_remote);

endmodule : sclh_top

/* File: sclh_partner.sv */
// far-side modem model: link clock, receive data and from-partner leads
// assumes the bench sets frame_on and the lead levels; the clock stands outside frames
`timescale 1ns/100ps
module sclh_partner
  import sclh_pkg::*;
(
  input  wire logic        frame_on,
  input  wire sclh_leads_s leads_set,
  output sclh_ser_s        line_rx,
  output sclh_leads_s      lead_pins
);
  logic [7:0] pat_q;

  // leads follow the bench setting, high = plus wire above minus wire
  assign lead_pins = leads_set;

  // 400 ns link clock in frames, data moves on falling edges
  initial begin
    line_rx = '0;
    pat_q   = 8'h5a;
    #13;
    forever begin
      #200;
      if (frame_on) begin
        line_rx.clk = ~line_rx.clk;
        if (!line_rx.clk) begin
          pat_q        = {pat_q[6:0], pat_q[7] ^ pat_q[5]};
          line_rx.data = pat_q[0];
        end
      end else begin
        line_rx.clk  = 1'b0;                // clock stands still
        line_rx.data = ~line_rx.data;       // released line, no stale value
      end
    end
  end
endmodule : sclh_partner

/* File: sclh_top_tb.sv */
// self-checking bench for sclh_top: lead forcing, gating, polarity, checks, loopback
// assumes sclh_partner as the far side; settings change 2 ns after rising edges
`timescale 1ns/100ps
module sclh_top_tb
  import sclh_pkg::*;
;
  typedef struct packed {
    sclh_line_e    m;
    sclh_out_cfg_s o;
    sclh_in_cfg_s  i;
    sclh_pol_s     p;
    logic          ia;
    logic          ub;
    logic          rs;
    sclh_lb_e      lb;
    logic          hd;
    logic          hr;
    logic          hc;
    sclh_ser_s     tx;
    sclh_leads_s   ld;
    logic          fr;
  } sclh_tbcfg_s;

  logic        ref_clk = 1'b0;
  logic        rst_n   = 1'b0;
  sclh_tbcfg_s c       = '0;
  sclh_tbcfg_s cn      = '0;
  sclh_ser_s   host_rx;
  sclh_ser_s   line_tx;
  sclh_ser_s   line_rx;
  sclh_leads_s lead_pins;
  sclh_leads_s lead_status;
  logic        dtr_pin;
  logic        dtr_unbal_sel;
  logic        rts_pin;
  logic        ctl_pin;
  logic        lb_req_local;
  logic        lb_req_remote;
  logic        link_ok;
  logic        cfg_err;
  logic        resync_active;
  int          num_errors  = 0;
  int          comparisons = 0;

  // 20 MHz clock
  always #25 ref_clk = ~ref_clk;

  sclh_top DUT (
    .ref_clk       (ref_clk),
    .rst_n         (rst_n),
    .clk_en        (1'b1),
    .line_mode     (c.m),
    .out_cfg       (c.o),
    .in_cfg        (c.i),
    .pol_cfg       (c.p),
    .ignore_all    (c.ia),
    .dtr_unbal     (c.ub),
    .resync_en     (c.rs),
    .resync_ms     (10'h001),
    .resync_s      (5'h01),
    .lb_mode       (c.lb),
    .host_dtr      (c.hd),
    .host_rts      (c.hr),
    .host_ctl      (c.hc),
    .host_tx       (c.tx),
    .host_rx       (host_rx),
    .line_rx       (line_rx),
    .line_tx       (line_tx),
    .lead_pins     (lead_pins),
    .dtr_pin       (dtr_pin),
    .dtr_unbal_sel (dtr_unbal_sel),
    .rts_pin       (rts_pin),
    .ctl_pin       (ctl_pin),
    .lb_req_local  (lb_req_local),
    .lb_req_remote (lb_req_remote),
    .lead_status   (lead_status),
    .link_ok       (link_ok),
    .cfg_err       (cfg_err),
    .resync_active (resync_active)
  );

  sclh_partner PARTNER (
    .frame_on  (c.fr),
    .leads_set (c.ld),
    .line_rx   (line_rx),
    .lead_pins (lead_pins)
  );

  // verdict and end of run
  task automatic results;
    $display("counts: %0d compares, %0d mismatches", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : results

  // single-bit comparison
  task automatic cmp1(input logic got, input logic exp, input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %b want %b", $time, m, got, exp);
    end
  endtask : cmp1

  // data and clock pair comparison
  task automatic cmp2(input sclh_ser_s got, input sclh_ser_s exp, input string m);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %0t %s: got %b want %b", $time, m, got, exp);
    end
  endtask : cmp2

  // settings land after an edge, then pass the sync and register stages
  task automatic apply;
    @(posedge ref_clk);
    #2;
    c = cn;
    repeat (4) @(posedge ref_clk);
    #2;
  endtask : apply

  // config check, refused settings fall back to an open link
  task automatic bad(input logic exp);
    apply();
    cmp1(cfg_err, exp, "config check");
    if (exp)
      cmp1(link_ok, 1'b1, "fallback link");
  endtask : bad

  // align to a link clock rise, then wait out the three-edge path
  task automatic link_sync;
    logic prev;
    int   k;
    #0.5;
    for (k = 0; k < 400; k++) begin
      prev = line_rx.clk;
      #1;
      if (!prev && line_rx.clk)
        break;
    end
    if (k == 400) begin
      cmp1(1'b0, 1'b1, "link clock timeout");
      results();
    end
    repeat (3) @(posedge ref_clk);
    #2;
  endtask : link_sync

  initial begin
    int   s;
    int   h;
    int   p;
    int   k;
    int   v;
    int   q;
    logic e;
    logic er;
    repeat (4) @(posedge ref_clk);
    #2;
    cmp1(link_ok, 1'b0, "link in reset");
    rst_n = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2;
    cmp1(dtr_unbal_sel, 1'b0, "balanced default");
    cmp1(cfg_err, 1'b0, "default legal");
    cmp1(resync_active, 1'b0, "no resync after reset");
    $display("test reset done");
    // output leads: every setting, host level and polarity
    for (s = 0; s < 3; s++) for (h = 0; h < 2; h++) for (p = 0; p < 2; p++) begin
      e      = ((s == 1) ? 1'b1 : (s == 2) ? 1'b0 : h[0]) ^ p[0];
      er     = ((s == 1) ? 1'b1 : (s == 2) ? 1'b0 : ~h[0]) ^ p[0];
      cn     = '0;
      cn.o   = {sclh_out_e'(s), sclh_out_e'(s), SCLH_OUT_NORMAL};
      cn.hd  = h[0];
      cn.hr  = ~h[0];
      cn.p   = {3'b000, p[0], p[0], 3'b000};
      apply();
      cmp1(dtr_pin, e, "dtr pin");
      cmp1(rts_pin, er, "rts pin");
      cn.m   = SCLH_LINE_X21;
      cn.o   = {SCLH_OUT_NORMAL, SCLH_OUT_NORMAL, sclh_out_e'(s)};
      cn.hc  = h[0];
      cn.p   = {6'b000000, p[0], 1'b0};
      apply();
      cmp1(ctl_pin, e, "control pin");
      cmp1(cfg_err, 1'b0, "x21 control legal");
    end
    $display("test output leads done");
    // input leads cts dcd dsr tm ind: every setting and level
    for (k = 0; k < 5; k++) for (s = 0; s < 3; s++) for (v = 0; v < 2; v++) begin
      q              = (k < 3) ? 4 - k : (k == 3) ? 0 : 1;
      cn             = '0;
      cn.m           = (k == 4) ? SCLH_LINE_X21 : SCLH_LINE_EIA530;
      cn.i[2*q +: 2] = s[1:0];
      cn.ld          = '1;
      cn.ld[4-k]     = v[0];
      apply();
      cmp1(lead_status[4-k], v[0], "lead status");
      cmp1(link_ok, !(s == 2 && v == 0), "link gating");
      cmp1(cfg_err, 1'b0, "lead setting legal");
    end
    cn      = '0;
    cn.i    = {SCLH_IN_REQUIRE, {4{SCLH_IN_NORMAL}}};
    cn.p    = 8'h80;
    cn.ld   = '1;
    apply();
    cmp1(link_ok, 1'b0, "inverted cts gates");
    cmp1(lead_status.cts, 1'b0, "inverted cts status");
    cn.m    = SCLH_LINE_X21;
    cn.i    = {{3{SCLH_IN_NORMAL}}, SCLH_IN_REQUIRE, SCLH_IN_NORMAL};
    cn.p    = 8'h01;
    apply();
    cmp1(link_ok, 1'b0, "inverted indication gates");
    cmp1(cfg_err, 1'b0, "indication polarity legal");
    $display("test input leads done");
    // refused and accepted combinations
    cn       = '0;
    cn.m     = SCLH_LINE_X21;
    cn.o.dtr = SCLH_OUT_ASSERT;
    bad(1'b1);
    cn.o     = '0;
    cn.i.cts = SCLH_IN_REQUIRE;
    bad(1'b1);
    cn.i     = '0;
    cn.p.tm  = 1'b1;
    bad(1'b1);
    cn.p     = '0;
    cn.lb    = SCLH_LB_LOCAL;
    bad(1'b1);
    cn.lb    = SCLH_LB_NONE;
    cn.ub    = 1'b1;
    bad(1'b1);
    cn       = '0;
    cn.o.ctl = SCLH_OUT_ASSERT;
    bad(1'b1);
    cn       = '0;
    cn.m     = SCLH_LINE_V35;
    cn.i.ind = SCLH_IN_IGNORE;
    bad(1'b1);
    cn.i     = '0;
    cn.i.tm  = SCLH_IN_REQUIRE;
    bad(1'b1);
    cn.i     = '0;
    cn.lb    = SCLH_LB_PARTNER_LOCAL;
    bad(1'b1);
    cn.lb    = SCLH_LB_REMOTE;
    bad(1'b0);
    cn       = '0;
    cn.ia    = 1'b1;
    bad(1'b0);
    cmp1(link_ok, 1'b1, "ignore all");
    cn.rs    = 1'b1;
    bad(1'b1);
    cmp1(resync_active, 1'b0, "no pulse before interval");
    cn.rs    = 1'b0;
    cn.i.cts = SCLH_IN_REQUIRE;
    bad(1'b1);
    cn       = '0;
    cn.ub    = 1'b1;
    bad(1'b0);
    cmp1(dtr_unbal_sel, 1'b1, "unbalanced dtr");
    $display("test config checks done");
    // loopback modes with the partner in frame
    cn       = '0;
    cn.fr    = 1'b1;
    cn.tx    = 2'b10;
    apply();
    cmp2(line_tx, cn.tx, "tx pass");
    link_sync();
    cmp2(host_rx, line_rx, "rx pass");
    cn.lb    = SCLH_LB_REMOTE;
    cn.tx    = 2'b01;
    apply();
    cmp2(host_rx, cn.tx, "remote to host");
    link_sync();
    cmp2(line_tx, line_rx, "remote to line");
    cn.lb    = SCLH_LB_LOCAL;
    cn.tx    = 2'b10;
    apply();
    cmp2(host_rx, cn.tx, "local to host");
    cmp2(line_tx, cn.tx, "local line tx");
    cmp1(link_ok, 1'b1, "local link up");
    cn.lb    = SCLH_LB_PARTNER_LOCAL;
    apply();
    cmp1(lb_req_local, 1'b1, "partner local req");
    cmp1(lb_req_remote, 1'b0, "partner local other");
    cn.lb    = SCLH_LB_PARTNER_REMOTE;
    apply();
    cmp1(lb_req_remote, 1'b1, "partner remote req");
    cmp1(lb_req_local, 1'b0, "partner remote other");
    $display("test loopback done");
    results();
  end
endmodule : sclh_top_tb
